// *** verilog/tat_pkg.sv ***
`default_nettype none
package tat_pkg;
  // apb register byte offsets
  localparam logic [7:0] TAT_CTRL_OFS   = 8'h00;
  localparam logic [7:0] TAT_STAT_OFS   = 8'h04;
  localparam logic [7:0] TAT_IRQ_OFS    = 8'h08;
  localparam logic [7:0] TAT_MASK_OFS   = 8'h0c;
  localparam logic [7:0] TAT_LEGACY_OFS = 8'h10;
  // control fields
  localparam int TAT_CTL_MODE_LO = 0;  // 2-bit line mode
  localparam int TAT_CTL_OD_EN   = 2;  // on-demand enable
  localparam int TAT_CTL_DUTY_LO = 4;  // 3-bit duty in eighths
  // legacy clock control fields
  localparam int TAT_LEG_DUTY_LO = 1;  // 3-bit duty in eighths
  localparam int TAT_LEG_EN      = 4;  // throttle enable
  // interrupt status bits
  localparam int TAT_IRQ_CRIT    = 0;
  localparam int TAT_IRQ_EXT_ON  = 1;
  localparam int TAT_IRQ_EXT_OFF = 2;
  localparam int TAT_IRQ_TRIP    = 3;
  localparam int TAT_IRQ_W       = 4;
  // thermal control modulation: 25% on, 32 us period at 5 ns
  localparam int TAT_CLK_PS      = 5000;
  localparam int TAT_TCC_PER_NS  = 32000;
  localparam int TAT_TCC_PER_CYC = (TAT_TCC_PER_NS * 1000) / TAT_CLK_PS;
  localparam int TAT_TCC_ON_PCT  = 25;
  localparam int TAT_TCC_ON_CYC  = (TAT_TCC_PER_CYC * TAT_TCC_ON_PCT) / 100;
  localparam int TAT_DUTY_STEPS  = 8;
  localparam logic [31:0] TAT_CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    TAT_MODE_IN    = 2'b00,
    TAT_MODE_OUT   = 2'b01,
    TAT_MODE_BIDIR = 2'b10,
    TAT_MODE_OFF   = 2'b11
  } tat_mode_e;

  // sensor status grouped together
  typedef struct packed {
    logic tcc_hot;     // thermal control trip reached
    logic crit_hot;    // critical temperature reached
    logic trip_hot;    // damage-risk temperature reached
  } tat_sense_s;

  // open-drain pin pair
  typedef struct packed {
    logic out;
    logic oe;
  } tat_pin_s;
endpackage
`default_nettype wire

// *** verilog/tat_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - external alert forces lowest perf state
// - alert drive released in package idle
// - alert redriven on idle exit if hot
// - thermal query link kept alive in idle
// - damage temperature forces shutdown output
// - critical hot with thermal control hot latches status, sticky, interrupt
// - software on-demand clock modulation duty
// - thermal control duty overrides on-demand duty
// - on-demand via control or legacy register
// - legacy modulation applies to all cores
// - alert driven while thermal control active
// - stay lowest state until line released
// - bidir: external assertion masked while driving
// - fixed 25 percent, 32 us modulation
module tat_ctrl #(
  parameter int NCORES = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire tat_pkg::tat_sense_s  sense,
  input  wire logic                 pkg_idle,
  input  wire logic                 thermal_alert_line_in,
  output tat_pkg::tat_pin_s         thermal_alert_line,
  output logic                      overtemp_shutdown_out,
  output logic                      lowest_perf_state,
  output logic      [NCORES-1:0]    core_clk_gate,
  output logic                      query_link_pwr,
  output logic                      irq
);
  import tat_pkg::*;

  // refuse core counts that the gate bus cannot carry
  if (NCORES < 1 || NCORES > 32) begin : g_bad_ncores
    $error("NCORES out of range");
  end

  // pin synchroniser for the alert line and sensor inputs
  logic [1:0] alert_sync_ff;
  logic [2:0] sense_s1_ff;
  logic [2:0] sense_s2_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alert_sync_ff <= 2'b11;
      sense_s1_ff   <= 3'b000;
      sense_s2_ff   <= 3'b000;
    end else if (clk_en) begin
      alert_sync_ff <= {alert_sync_ff[0], thermal_alert_line_in};
      sense_s1_ff   <= sense;
      sense_s2_ff   <= sense_s1_ff;
    end
  end
  logic line_low;
  logic tcc_hot;
  logic crit_hot;
  logic trip_hot;
  assign line_low = ~alert_sync_ff[1];
  assign tcc_hot  = sense_s2_ff[2];
  assign crit_hot = sense_s2_ff[1];
  assign trip_hot = sense_s2_ff[0];

  // registers
  logic [31:0]         ctrl_ff,   nxt_ctrl;
  logic [4:0]          leg_ff,    nxt_leg;
  logic [TAT_IRQ_W-1:0] ist_ff,   nxt_ist;
  logic [TAT_IRQ_W-1:0] mask_ff,  nxt_mask;
  logic                crit_ff,   nxt_crit;
  logic                ext_ff,    nxt_ext;
  logic                drive_ff,  nxt_drive;
  logic [1:0]          dhist_ff,  nxt_dhist;
  logic                trip_ff,   nxt_trip;
  logic [12:0]         per_ff,    nxt_per;
  logic [NCORES-1:0]   gate_ff,   nxt_gate;
  logic                lps_ff,    nxt_lps;
  logic [31:0]         prdata_ff, nxt_prdata;
  logic                pready_ff, nxt_pready;
  logic                perr_ff,   nxt_perr;
  logic                irq_ff,    nxt_irq;

  tat_mode_e mode;
  assign mode = tat_mode_e'(ctrl_ff[TAT_CTL_MODE_LO +: 2]);

  // duty in eighths to on-cycles of the period
  function automatic logic [12:0] duty_cyc(input logic [2:0] d);
    logic [31:0] t;
    t = (TAT_TCC_PER_CYC * (32'(d) + 32'd1)) / TAT_DUTY_STEPS;
    return t[12:0];
  endfunction

  logic acc;
  logic wr;
  logic done;
  logic hit;
  logic mode_in;
  logic ext_seen;
  logic od_on;
  logic leg_on;
  logic [12:0] on_cyc;
  logic mod_on;
  assign acc = psel & penable & ~pready_ff;
  // writes land on the edge that completes the transfer
  assign done = psel & penable & pready_ff;
  assign wr   = done & pwrite;
  assign hit = (paddr == TAT_CTRL_OFS) || (paddr == TAT_STAT_OFS) ||
               (paddr == TAT_IRQ_OFS)  || (paddr == TAT_MASK_OFS) ||
               (paddr == TAT_LEGACY_OFS);
  assign mode_in = (mode == TAT_MODE_IN) || (mode == TAT_MODE_BIDIR);
  // own drive hides the line in bidir mode, and so does its echo
  // through the two-stage synchroniser after the drive is released
  assign ext_seen = mode_in & line_low & ~drive_ff & ~|dhist_ff;
  assign od_on  = ctrl_ff[TAT_CTL_OD_EN];
  assign leg_on = leg_ff[TAT_LEG_EN];
  // thermal control duty wins over software duty
  always_comb begin
    if (tcc_hot) on_cyc = 13'(TAT_TCC_ON_CYC);
    else if (leg_on) on_cyc = duty_cyc(leg_ff[TAT_LEG_DUTY_LO +: 3]);
    else on_cyc = duty_cyc(ctrl_ff[TAT_CTL_DUTY_LO +: 3]);
  end
  // external assertion suppresses modulation
  assign mod_on = (tcc_hot | od_on | leg_on) & ~ext_ff;

  // next-state for thermal and modulation logic
  always_comb begin
    nxt_ext   = ext_seen;
    nxt_lps   = ext_seen;
    // drive while active, drop in idle, redrive on exit
    nxt_drive = tcc_hot & ~pkg_idle &
                (mode != TAT_MODE_IN) & (mode != TAT_MODE_OFF);
    nxt_dhist = {dhist_ff[0], drive_ff};
    nxt_trip  = trip_ff | trip_hot;
    nxt_crit  = crit_hot & tcc_hot;
    nxt_per   = (per_ff == 13'(TAT_TCC_PER_CYC - 1)) ? 13'h0 :
                per_ff + 13'h1;
    if (!mod_on) nxt_per = 13'h0;
    // all cores gated together
    nxt_gate  = (mod_on && per_ff >= on_cyc) ? {NCORES{1'b1}} :
                {NCORES{1'b0}};
    if (trip_ff) nxt_gate = {NCORES{1'b1}};
  end

  // next-state for registers and apb
  logic [TAT_IRQ_W-1:0] ev;
  always_comb begin
    ev = '0;
    ev[TAT_IRQ_CRIT]    = nxt_crit & ~crit_ff;
    ev[TAT_IRQ_EXT_ON]  = ext_seen & ~ext_ff;
    ev[TAT_IRQ_EXT_OFF] = ~ext_seen & ext_ff;
    ev[TAT_IRQ_TRIP]    = trip_hot & ~trip_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_leg    = leg_ff;
    nxt_mask   = mask_ff;
    nxt_ist    = ist_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = acc;
    nxt_perr   = acc & ~hit;
    if (wr && paddr == TAT_CTRL_OFS)   nxt_ctrl = pwdata;
    if (wr && paddr == TAT_LEGACY_OFS) nxt_leg = pwdata[4:0];
    if (wr && paddr == TAT_MASK_OFS)   nxt_mask = pwdata[TAT_IRQ_W-1:0];
    // write one clears, events win over clear
    if (wr && paddr == TAT_IRQ_OFS)
      nxt_ist = ist_ff & ~pwdata[TAT_IRQ_W-1:0];
    nxt_ist = nxt_ist | ev;
    if (acc && !pwrite) begin
      unique case (paddr)
        TAT_CTRL_OFS:   nxt_prdata = ctrl_ff;
        TAT_STAT_OFS:   nxt_prdata = {26'h0, lps_ff, drive_ff, ext_ff,
                                      trip_ff, crit_ff, tcc_hot};
        TAT_IRQ_OFS:    nxt_prdata = {28'h0, ist_ff};
        TAT_MASK_OFS:   nxt_prdata = {28'h0, mask_ff};
        TAT_LEGACY_OFS: nxt_prdata = {27'h0, leg_ff};
        default:        nxt_prdata = 32'h0;
      endcase
    end
    nxt_irq = |(nxt_ist & nxt_mask);
  end

  // register all state except the synchronisers and query link power
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_ff   <= TAT_CTRL_RST;
      leg_ff    <= 5'h00;
      ist_ff    <= '0;
      mask_ff   <= '0;
      crit_ff   <= 1'b0;
      ext_ff    <= 1'b0;
      drive_ff  <= 1'b0;
      dhist_ff  <= 2'b00;
      trip_ff   <= 1'b0;
      per_ff    <= 13'h0;
      gate_ff   <= '0;
      lps_ff    <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      perr_ff   <= 1'b0;
      irq_ff    <= 1'b0;
    end else if (clk_en) begin
      ctrl_ff   <= nxt_ctrl;
      leg_ff    <= nxt_leg;
      ist_ff    <= nxt_ist;
      mask_ff   <= nxt_mask;
      crit_ff   <= nxt_crit;
      ext_ff    <= nxt_ext;
      drive_ff  <= nxt_drive;
      dhist_ff  <= nxt_dhist;
      trip_ff   <= nxt_trip;
      per_ff    <= nxt_per;
      gate_ff   <= nxt_gate;
      lps_ff    <= nxt_lps;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      perr_ff   <= nxt_perr;
      irq_ff    <= nxt_irq;
    end
  end

  // query link power held on in every idle state
  logic rst_b_pw_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) rst_b_pw_ff <= 1'b0;
    else if (clk_en) rst_b_pw_ff <= 1'b1;
  end

  // outputs
  assign prdata                 = prdata_ff;
  assign pready                 = pready_ff;
  assign pslverr                = perr_ff;
  assign thermal_alert_line     = tat_pin_s'{out: 1'b0, oe: drive_ff};
  assign overtemp_shutdown_out  = trip_ff;
  assign lowest_perf_state      = lps_ff;
  assign core_clk_gate          = gate_ff;
  assign query_link_pwr         = rst_b_pw_ff;
  assign irq                    = irq_ff;

  // assertions
  a_trip_shut: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && trip_hot |=> overtemp_shutdown_out)
    else $error("shutdown not raised");
  a_trip_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    overtemp_shutdown_out |=> overtemp_shutdown_out)
    else $error("shutdown dropped");
  a_trip_gate: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && overtemp_shutdown_out |=> &core_clk_gate)
    else $error("clocks running after shutdown");
  a_ext_lowest: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && ext_seen |=> lowest_perf_state)
    else $error("no lowest state");
  a_ext_no_mod: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && ext_ff && !trip_ff |=> core_clk_gate == '0)
    else $error("modulation during external hold");
  a_idle_release: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && pkg_idle |=> !thermal_alert_line.oe)
    else $error("drive in idle");
  a_wake_redrive: assert property (@(posedge clk)
    disable iff (!rst_b)
    clk_en && !pkg_idle && tcc_hot && mode == TAT_MODE_BIDIR
    |=> thermal_alert_line.oe)
    else $error("no redrive");
  a_bidir_mask: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && drive_ff |=> !ext_ff)
    else $error("external seen while driving");
  a_crit_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && crit_hot && tcc_hot && !crit_ff |=> ist_ff[TAT_IRQ_CRIT])
    else $error("critical not latched");
  a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && ist_ff[TAT_IRQ_CRIT] && !(wr && paddr == TAT_IRQ_OFS)
    |=> ist_ff[TAT_IRQ_CRIT])
    else $error("critical sticky lost");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    irq == |(ist_ff & mask_ff))
    else $error("interrupt level wrong");
  a_mod_off: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && !(tcc_hot || od_on || leg_on) && !trip_ff
    |=> core_clk_gate == '0)
    else $error("modulation with no source");
  a_gate_uniform: assert property (@(posedge clk) disable iff (!rst_b)
    core_clk_gate == '0 || &core_clk_gate)
    else $error("cores gated unevenly");
  a_query_alive: assert property (@(posedge clk) disable iff (!rst_b)
    pkg_idle ##1 1'b1 |-> query_link_pwr)
    else $error("query link off");
  a_tcc_period: assert property (@(posedge clk) disable iff (!rst_b)
    per_ff <= 13'(TAT_TCC_PER_CYC - 1))
    else $error("period overrun");
  a_pready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    clk_en && pready |=> !pready)
    else $error("ready held too long");
  // cover points for the main scenarios
  c_ext_event: cover property (@(posedge clk) ext_seen ##1 lowest_perf_state);
  c_tcc_gate: cover property (@(posedge clk) tcc_hot && core_clk_gate != '0);
  c_trip: cover property (@(posedge clk) overtemp_shutdown_out);
  c_od_gate: cover property (@(posedge clk) od_on && core_clk_gate != '0);
  c_irq: cover property (@(posedge clk) irq);
endmodule
`default_nettype wire

// *** bench/tat_plat_mon.sv ***
`timescale 1ns/1ps
`default_nettype none
// platform regulator monitor on the shared open-drain alert line
module tat_plat_mon (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic vr_hot,
  output logic      pull_oe
);
  // pull the line low while the regulator is over its limit
  always_ff @(posedge clk) begin
    pull_oe <= rst_b & vr_hot;
  end
endmodule
`default_nettype wire

// *** bench/test_thermal_alert_throttle_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_thermal_alert_throttle_ctrl;
  import tat_pkg::*;
  logic              clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic              pkg_idle, vr_hot, pull_oe, shut, lps, qpwr, irq, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        gate;
  tat_sense_s        sense;
  tat_pin_s          alert;
  wire logic         line_lvl = !pull_oe && (!alert.oe || alert.out);
  int                n_mismatch, n_compared, cyc, on, d;
  integer            seed;

  tat_ctrl dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
    .pkg_idle(pkg_idle), .thermal_alert_line_in(line_lvl),
    .thermal_alert_line(alert), .overtemp_shutdown_out(shut),
    .lowest_perf_state(lps), .core_clk_gate(gate),
    .query_link_pwr(qpwr), .irq(irq));
  tat_plat_mon plat (.clk(clk), .rst_b(rst_b), .vr_hot(vr_hot),
    .pull_oe(pull_oe));

  always #2.5 clk = ~clk;

  // cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc > 90000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, waits for pready; the cycle ceiling ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= v; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("pready_wait", 2, n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // count clock-on cycles over one modulation period
  task automatic measure();
    repeat (TAT_TCC_PER_CYC) @(posedge clk);
    on = 0;
    repeat (TAT_TCC_PER_CYC) begin
      @(posedge clk);
      if (gate === 4'h0) on++;
      else if (gate !== 4'hf) chk("gate_equal", 4'hf, gate);
    end
  endtask

  function automatic int exp_on(input int duty);
    return ((duty + 1) * TAT_TCC_PER_CYC) / TAT_DUTY_STEPS;
  endfunction

  task automatic settle(); repeat (8) @(posedge clk); endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; sense = '0; pkg_idle = 0; vr_hot = 0; seed = 32'h16cb;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("qpwr", 1, qpwr);
    apb(1, TAT_MASK_OFS, 32'hf);
    apb(0, 8'h40, 0);
    chk("unmapped_err", 1, err);
    chk("unmapped_rd", 0, rd);
    // external alert in input mode
    vr_hot <= 1'b1; settle();
    chk("lps_on", 1, lps);
    chk("no_mod", 0, gate);
    chk("irq_ext", 1, irq);
    vr_hot <= 1'b0; settle();
    chk("lps_off", 0, lps);
    apb(0, TAT_IRQ_OFS, 0);
    chk("irq_st", 32'h6, rd & 32'hf);
    apb(1, TAT_IRQ_OFS, 32'h6);
    chk("irq_clr", 0, irq);
    $display("test external alert done");
    // bidir: own drive hides external assertion
    apb(1, TAT_CTRL_OFS, 32'h2);
    sense.tcc_hot <= 1'b1; settle();
    chk("drive", 1, alert.oe);
    chk("drive_lvl", 0, alert.out);
    vr_hot <= 1'b1; settle();
    chk("lps_masked", 0, lps);
    sense.tcc_hot <= 1'b0; settle(); settle();
    chk("lps_late", 1, lps);
    vr_hot <= 1'b0; sense.tcc_hot <= 1'b1; settle();
    pkg_idle <= 1'b1; settle();
    chk("idle_rel", 0, alert.oe);
    chk("idle_qpwr", 1, qpwr);
    pkg_idle <= 1'b0; settle();
    chk("idle_exit", 1, alert.oe);
    sense.tcc_hot <= 1'b0;
    apb(1, TAT_IRQ_OFS, 32'hf);
    $display("test bidir and idle done");
    // on-demand, legacy and thermal override duties
    d = $unsigned($random(seed)) % 8;
    apb(1, TAT_CTRL_OFS, 32'h4 | (d << TAT_CTL_DUTY_LO));
    measure();
    chk("od_on", exp_on(d), on);
    apb(1, TAT_CTRL_OFS, 0);
    d = $unsigned($random(seed)) % 8;
    apb(1, TAT_LEGACY_OFS, 32'h10 | (d << TAT_LEG_DUTY_LO));
    measure();
    chk("leg_on", exp_on(d), on);
    apb(1, TAT_LEGACY_OFS, 0);
    apb(1, TAT_CTRL_OFS, 32'h74);
    sense.tcc_hot <= 1'b1;
    measure();
    chk("tcc_on", TAT_TCC_ON_CYC, on);
    $display("test modulation done");
    // critical sticky and interrupt
    apb(1, TAT_IRQ_OFS, 32'hf);
    sense.crit_hot <= 1'b1; settle();
    chk("irq_crit", 1, irq);
    sense <= '0; settle();
    apb(0, TAT_IRQ_OFS, 0);
    chk("crit_sticky", 1, rd[TAT_IRQ_CRIT]);
    apb(1, TAT_IRQ_OFS, 32'h1);
    apb(0, TAT_IRQ_OFS, 0);
    chk("crit_clr", 0, rd[TAT_IRQ_CRIT]);
    sense.trip_hot <= 1'b1; settle();
    chk("trip", 1, shut);
    sense <= '0; settle();
    chk("trip_hold", 1, shut);
    $display("test critical and trip done");
    conclude();
  end
endmodule
`default_nettype wire
